// file: design/retriggerable_multivibrator.sv
// Implementation choices: the register offsets and the Avalon-MM slave port.
`include "multivib_params.svh"
`default_nettype none
module retriggerable_multivibrator #(
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire multivib_pkg::ctrl_pins_s ctrl_pins,
  output logic pulse_out,
  output logic pulse_out_n,
  output logic osc_out,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);
  import multivib_pkg::*;

  localparam int RECOV_CYC = `RECOVERY_CYC;
  localparam logic [CNT_W-1:0] RECOV_LAST = CNT_W'(`RECOVERY_CYC - 1);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  logic [5:0] pin_lvl;
  logic [5:0] pin_next;
  ctrl_pins_s lvl_s;
  ctrl_pins_s nxt_s;
  logic mc_now;
  logic astable_en;
  logic ext_now;
  logic comb_q;
  logic comb_next;
  logic trig_edge;

  state_e state_q;
  state_e state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic out_q;
  logic out_d;
  logic out_n_q;
  logic accept;
  logic osc_q;
  logic osc_d;
  logic [CNT_W-1:0] osc_cnt_q;
  logic [CNT_W-1:0] osc_cnt_d;
  logic osc_run;
  logic osc_tick;

  logic [CNT_W-1:0] pulse_len_q;
  logic [CNT_W-1:0] osc_half_q;
  logic [CNT_W-1:0] trig_cnt_q;
  logic [CNT_W-1:0] trig_cnt_d;
  logic [CNT_W-1:0] len_last;
  logic [CNT_W-1:0] half_last;
  logic waitrequest_q;
  word_t readdata_q;

  // all control pins share one synchroniser instance
  sync_filter #(
    .W(6),
    .RST_VAL(`PIN_RST)
  ) u_pins (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(ctrl_pins),
    .lvl(pin_lvl),
    .lvl_next(pin_next)
  );

  // pin decode; the filtered next value saves a cycle of latency
  assign lvl_s = pin_lvl;
  assign nxt_s = pin_next;
  assign mc_now = nxt_s.master_clear;
  assign astable_en = nxt_s.free_run_en | ~nxt_s.free_run_en_n;
  assign ext_now = nxt_s.pulse_extend_in;

  // trigger is true polarity of rise pin and low fall pin, as one gate
  assign comb_q = lvl_s.trig_rise & ~lvl_s.trig_fall;
  assign comb_next = nxt_s.trig_rise & ~nxt_s.trig_fall;
  assign trig_edge = comb_next & ~comb_q;

  // zero in a count register would stall the counters, so read it as one
  assign len_last = (pulse_len_q == '0) ? '0 : pulse_len_q - ONE;
  assign half_last = (osc_half_q == '0) ? '0 : osc_half_q - ONE;

  // oscillator runs in free-run and during a one-shot pulse
  assign osc_run = (state_q == ST_FREE || state_q == ST_PULSE) && !mc_now;
  assign osc_tick = osc_run && (osc_cnt_q == half_last);
  assign osc_cnt_d = (!osc_run || osc_tick) ? '0 : osc_cnt_q + ONE;
  assign osc_d = !osc_run ? 1'b0 : (osc_tick ? ~osc_q : osc_q);

  // core sequencer; master clear overrides every state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    out_d = out_q;
    accept = 1'b0;
    if (mc_now) begin
      state_d = ST_IDLE;
      cnt_d = '0;
      out_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (trig_edge) begin
            state_d = ST_PULSE;
            cnt_d = '0;
            out_d = 1'b1;
            accept = 1'b1;
          end else if (astable_en) begin
            state_d = ST_FREE;
          end
        end
        ST_FREE: begin
          if (!astable_en) begin
            state_d = ST_IDLE;
            out_d = 1'b0;
          end else if (osc_tick && !osc_q) begin
            out_d = ~out_q;
          end
        end
        ST_PULSE: begin
          if (trig_edge && ext_now) begin
            cnt_d = '0;
            accept = 1'b1;
          end else if (cnt_q == len_last) begin
            state_d = ST_RECOVER;
            cnt_d = '0;
            out_d = 1'b0;
          end else begin
            cnt_d = cnt_q + ONE;
          end
        end
        ST_RECOVER: begin
          // triggers are ignored here; the length does not matter
          if (cnt_q == RECOV_LAST) begin
            state_d = ST_IDLE;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + ONE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // core state and outputs; the complement has its own flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      out_q <= 1'b0;
      out_n_q <= 1'b1;
      osc_q <= 1'b0;
      osc_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      out_n_q <= ~out_d;
      osc_q <= osc_d;
      osc_cnt_q <= osc_cnt_d;
    end
  end

  assign pulse_out = out_q;
  assign pulse_out_n = out_n_q;
  assign osc_out = osc_q;

  // avalon slave: fixed one wait cycle, answer on the following edge
  logic bus_req;
  logic bus_ack;
  logic wr_fire;
  logic rd_take;
  logic sel_len;
  logic sel_half;
  logic sel_stat;
  logic sel_cnt;
  word_t wmask;
  word_t status_w;
  word_t rd_mux;
  logic [CNT_W-1:0] len_wr;
  logic [CNT_W-1:0] half_wr;

  assign bus_req = read | write;
  assign bus_ack = !waitrequest_q;
  assign wr_fire = write & bus_ack;
  assign rd_take = read & waitrequest_q;
  assign sel_len = (address == `OFF_PULSE_LEN);
  assign sel_half = (address == `OFF_OSC_HALF);
  assign sel_stat = (address == `OFF_STATUS);
  assign sel_cnt = (address == `OFF_TRIG_CNT);
  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                  {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign len_wr = (pulse_len_q & ~wmask[CNT_W-1:0]) | (writedata[CNT_W-1:0] & wmask[CNT_W-1:0]);
  assign half_wr = (osc_half_q & ~wmask[CNT_W-1:0]) | (writedata[CNT_W-1:0] & wmask[CNT_W-1:0]);

  // status word; unused bits read zero
  always_comb begin
    status_w = '0;
    status_w[`STAT_OUT] = out_q;
    status_w[`STAT_OSC] = osc_q;
    status_w[`STAT_PULSE] = (state_q == ST_PULSE);
    status_w[`STAT_FREE] = (state_q == ST_FREE);
    status_w[`STAT_RECOVER] = (state_q == ST_RECOVER);
    status_w[`STAT_CLEAR] = mc_now;
  end

  // unmapped addresses read zero and ignore writes
  assign rd_mux = sel_len ? word_t'(pulse_len_q) :
                  sel_half ? word_t'(osc_half_q) :
                  sel_stat ? status_w :
                  sel_cnt ? word_t'(trig_cnt_q) : '0;

  // a trigger in the clearing cycle still counts
  assign trig_cnt_d = (wr_fire && sel_cnt) ? CNT_W'(accept) : trig_cnt_q + CNT_W'(accept);

  // bus handshake and read capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest_q <= 1'b1;
      readdata_q <= '0;
    end else begin
      waitrequest_q <= !(bus_req && waitrequest_q);
      if (rd_take) begin
        readdata_q <= rd_mux;
      end
    end
  end

  // writable registers; period counts take effect at the next compare
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_len_q <= CNT_W'(`PULSE_LEN_RST);
      osc_half_q <= CNT_W'(`OSC_HALF_RST);
      trig_cnt_q <= '0;
    end else begin
      if (wr_fire && sel_len) begin
        pulse_len_q <= len_wr;
      end
      if (wr_fire && sel_half) begin
        osc_half_q <= half_wr;
      end
      trig_cnt_q <= trig_cnt_d;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;

  // helper: high cycles since the pulse start or last pulse_extend_in
  logic [CNT_W-1:0] hi_cnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt_q <= '0;
    end else if (!out_q || (state_q == ST_PULSE && accept)) begin
      hi_cnt_q <= '0;
    end else begin
      hi_cnt_q <= hi_cnt_q + ONE;
    end
  end

  a_outs_inverse: assert property (@(posedge clk) disable iff (sys_rst)
    out_q == ~out_n_q)
    else $error("pulse outputs not inverse");

  a_clear_idle: assert property (@(posedge clk) disable iff (sys_rst)
    mc_now |=> (!out_q && !osc_q && state_q == ST_IDLE))
    else $error("master clear did not idle outputs");

  a_clear_holds: assert property (@(posedge clk) disable iff (sys_rst)
    (mc_now && $past(mc_now)) |-> !out_q)
    else $error("pulse while master clear held");

  a_trig_start: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_IDLE && trig_edge && !mc_now) |=> (out_q && state_q == ST_PULSE))
    else $error("trigger edge did not start pulse");

  a_pulse_length: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(out_q) && $past(state_q) == ST_PULSE && !$past(mc_now))
    |-> $past(hi_cnt_q) == $past(len_last))
    else $error("one-shot pulse length wrong");

  a_retrig_restart: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_PULSE && trig_edge && ext_now && !mc_now && len_last != '0)
    |=> (cnt_q == '0 && out_q) ##1 out_q)
    else $error("pulse_extend_in did not restart timing");

  a_plain_no_restart: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_PULSE && trig_edge && !ext_now && !mc_now && cnt_q != len_last)
    |=> cnt_q == $past(cnt_q) + ONE)
    else $error("plain trigger restarted pulse");

  a_recover_bound: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(state_q == ST_RECOVER) |-> ##[1:RECOV_CYC] state_q != ST_RECOVER)
    else $error("recovery too long");

  a_gate_off: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_FREE && !astable_en) |=> (state_q == ST_IDLE && !out_q))
    else $error("free-run not gated off");

  a_osc_half: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_FREE && state_d == ST_FREE && osc_tick && !osc_q)
    |=> (out_q != $past(out_q) && osc_q))
    else $error("pulse output not toggling on oscillator rise");

  a_free_osc: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_FREE && osc_tick && state_d == ST_FREE) |=> osc_q != $past(osc_q))
    else $error("free-run oscillator did not toggle");

  a_bus_answer: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_req && waitrequest_q) |=> !waitrequest_q ##1 waitrequest_q)
    else $error("bus answer not one cycle");

  c_pulse_extend_in: cover property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_PULSE && accept);
  c_pulse_done: cover property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_RECOVER ##1 state_q == ST_IDLE);
  c_free_toggle: cover property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_FREE && $rose(out_q));
  c_clear_in_pulse: cover property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_PULSE && mc_now);

endmodule // retriggerable_multivibrator
`default_nettype wire

// file: design/multivib_params.svh
`ifndef MULTIVIB_PARAMS_SVH
`define MULTIVIB_PARAMS_SVH

// register byte offsets
`define OFF_PULSE_LEN 4'h0
`define OFF_OSC_HALF 4'h4
`define OFF_STATUS 4'h8
`define OFF_TRIG_CNT 4'hC

// register reset values, in clock cycles
`define PULSE_LEN_RST 32'h0000_0064
`define OSC_HALF_RST 32'h0000_0032

// status bit positions
`define STAT_OUT 0
`define STAT_OSC 1
`define STAT_PULSE 2
`define STAT_FREE 3
`define STAT_RECOVER 4
`define STAT_CLEAR 5

// pin synchroniser reset values, ordered as the pin struct
`define PIN_RST 6'h05

// timing
`define CLK_PERIOD_NS 25
`define RECOVERY_NS 50
`define RECOVERY_CYC ((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: design/multivib_pkg.sv
`default_nettype none
package multivib_pkg;

  // operating state of the multivibrator core
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FREE,
    ST_PULSE,
    ST_RECOVER
  } state_e;

  // control pins from the external logic, first field is the top bit
  typedef struct packed {
    logic trig_rise;
    logic trig_fall;
    logic free_run_en;
    logic free_run_en_n;
    logic pulse_extend_in;
    logic master_clear;
  } ctrl_pins_s;

  typedef logic [31:0] word_t;

endpackage
`default_nettype wire

// file: design/sync_filter.sv
`default_nettype none
module sync_filter #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] lvl,
  output logic [W-1:0] lvl_next
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] differ;

  // three stages; stage one feeds only stage two
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_next;
    end
  end

  // a change counts once stages two and three agree
  assign differ = s2_q ^ s3_q;
  assign lvl_next = (~differ & s3_q) | (differ & lvl_q);
  assign lvl = lvl_q;

endmodule // sync_filter
`default_nettype wire

// file: sim/control_model.sv
`default_nettype none
module control_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic trig,
  input wire logic edge_fall,
  input wire logic retrig_mode,
  input wire logic count_mode,
  input wire logic free,
  input wire logic clr,
  input wire logic [3:0] count_n,
  input wire logic pulse_out,
  output var multivib_pkg::ctrl_pins_s ctrl_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  import multivib_pkg::*;
  logic [3:0] n_q;
  logic run_q;
  logic po_q;
  // in count mode the trigger only clears the counter and starts the gate, so no one-shot hides the count
  wire logic edge_trig = trig & ~count_mode;
  // both pins switch together on a mode change, so no false edge is seen
  // one driver for the whole pin word, so the variable has a single writer
  assign ctrl_pins = ctrl_pins_s'{
    trig_rise: edge_fall ? 1'b1 : edge_trig,
    trig_fall: edge_fall ? ~edge_trig : 1'b0,
    free_run_en: free,
    free_run_en_n: ~run_q,
    pulse_extend_in: retrig_mode & edge_trig,
    master_clear: clr | sys_rst
  };
  // external count-down: counts pulse_out rises, gates via inverted enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 1'b0;
      n_q <= 4'h0;
      po_q <= 1'b0;
    end else begin
      po_q <= pulse_out;
      if (count_mode & trig) begin
        run_q <= 1'b1;
        n_q <= 4'h0;
      end else if (run_q & pulse_out & ~po_q) begin
        n_q <= n_q + 4'h1;
        if (n_q + 4'h1 == count_n) run_q <= 1'b0;
      end
    end
  end
endmodule // control_model
`default_nettype wire

// file: sim/retriggerable_multivibrator_bench.sv
`default_nettype none
module retriggerable_multivibrator_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import multivib_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic trig = 1'b0, edge_fall = 1'b0, retrig_mode = 1'b0, count_mode = 1'b0;
  logic free = 1'b0, clr = 1'b1;
  logic [3:0] count_n = 4'h0;
  logic [3:0] address = 4'h0;
  logic [3:0] byteenable = 4'h0;
  logic read = 1'b0, write = 1'b0;
  word_t writedata = 32'h0000_0000;
  word_t readdata, q;
  logic pulse_out, pulse_out_n, osc_out, waitrequest;
  ctrl_pins_s ctrl_pins;
  int mismatches = 0;
  int checks = 0;
  int hi, r, i;
  logic p;
  int lens [2] = '{3, 20};
  int exp_hi [2] = '{26, 8};

  always #12.5 clk = ~clk;

  control_model i_ctrl (.clk(clk), .sys_rst(sys_rst), .trig(trig), .edge_fall(edge_fall),
    .retrig_mode(retrig_mode), .count_mode(count_mode), .free(free), .clr(clr),
    .count_n(count_n), .pulse_out(pulse_out), .ctrl_pins(ctrl_pins));
  retriggerable_multivibrator i_dut (.clk(clk), .sys_rst(sys_rst), .ctrl_pins(ctrl_pins),
    .pulse_out(pulse_out), .pulse_out_n(pulse_out_n), .osc_out(osc_out), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest));

  task automatic check(input string what, input word_t seen, input word_t exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one avalon access; the request holds until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input word_t d, input logic [3:0] be,
                     output word_t rdv);
    int n;
    n = 0;
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    check("bus latency", n, 2); // one wait cycle, answer at the second edge
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input word_t d);
    word_t x;
    bus(1'b1, a, d, 4'hf, x);
  endtask

  task automatic rd(input logic [3:0] a, output word_t d);
    bus(1'b0, a, 32'h0000_0000, 4'hf, d);
  endtask

  task automatic pulse_trig(input int w);
    @(posedge clk);
    trig <= 1'b1;
    repeat (w) @(posedge clk);
    trig <= 1'b0;
  endtask

  // first whole high stretch of pulse_out or osc_out, 0 if none;
  // a stretch already running at the start is skipped, it would read short
  task automatic measure(input logic sel, output int h);
    logic v;
    logic low;
    h = 0;
    low = 1'b0;
    for (int n = 0; n < 140; n++) begin
      @(negedge clk);
      check("pulse_out_n", pulse_out_n, 1'(~pulse_out));
      v = sel ? osc_out : pulse_out;
      if (v !== 1'b1) begin
        if (h > 0 || n >= 40) break;
        low = 1'b1;
      end else if (low) begin
        h++;
      end
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog: the tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, unmapped place, clear holds outputs idle
    rd(4'h0, q);
    check("pulse_len", q, 32'h0000_0064);
    rd(4'h4, q);
    check("osc_half", q, 32'h0000_0032);
    rd(4'h2, q);
    check("unmapped", q, 32'h0000_0000);
    rd(4'h8, q);
    check("status clear", q[5], 1);
    fork pulse_trig(3); measure(1'b0, hi); join
    check("pulse under clear", hi, 0);
    $display("test reset done");
    @(posedge clk);
    clr <= 1'b0;
    repeat (5) @(posedge clk);
    // byte lanes, read-only status, trigger counter clear
    wr(4'h0, 32'h0000_0008);
    bus(1'b1, 4'h0, 32'haaaa_aa03, 4'h1, q);
    rd(4'h0, q);
    check("pulse_len lane", q, 32'h0000_0003);
    wr(4'h8, 32'hffff_ffff);
    rd(4'h8, q);
    check("status idle", q, 32'h0000_0000);
    wr(4'h4, 32'h0000_0002);
    wr(4'hc, 32'h0000_0000);
    $display("test registers done");
    // short then long trigger, the second right after the first pulse ends
    foreach (lens[k]) begin
      wr(4'h0, lens[k]);
      fork pulse_trig(3); measure(1'b0, hi); join
      check("short trigger", hi, lens[k]);
      fork pulse_trig(lens[k] + 10); measure(1'b0, hi); join
      check("long trigger", hi, lens[k]);
    end
    rd(4'hc, q);
    check("trig_cnt", q, 32'h0000_0004);
    @(posedge clk);
    edge_fall <= 1'b1;
    repeat (5) @(posedge clk);
    fork pulse_trig(3); measure(1'b0, hi); join
    check("falling trigger", hi, 20);
    @(posedge clk);
    edge_fall <= 1'b0;
    $display("test one-shot done");
    // trigger every 6 cycles: extend on keeps high, extend off ignores
    wr(4'h0, 32'h0000_0008);
    for (i = 0; i < 2; i++) begin
      retrig_mode <= (i == 0);
      fork
        repeat (4) begin
          pulse_trig(3);
          repeat (2) @(posedge clk);
        end
        measure(1'b0, hi);
      join
      check("pulse_extend_in", hi, exp_hi[i]);
      repeat (40) @(posedge clk);
    end
    $display("test pulse_extend_in done");
    // free run: pulse_out high 2*osc_half, osc_out high osc_half
    free <= 1'b1;
    measure(1'b0, hi);
    check("free pulse", hi, 4);
    measure(1'b1, hi);
    check("free osc", hi, 2);
    rd(4'h8, q);
    check("status free", q[3], 1);
    @(posedge clk);
    free <= 1'b0;
    repeat (6) @(negedge clk);
    check("gated pulse", {pulse_out, pulse_out_n, osc_out}, 3'b010);
    // external count-down gate gives exactly count_n periods
    @(posedge clk);
    count_mode <= 1'b1;
    count_n <= 4'h3;
    pulse_trig(3);
    r = 0;
    p = 1'b0;
    repeat (150) begin
      @(negedge clk);
      if (pulse_out === 1'b1 && p !== 1'b1) r++;
      p = pulse_out;
    end
    check("counted periods", r, 3);
    @(posedge clk);
    count_mode <= 1'b0;
    $display("test free run done");
    // clear in mid-pulse ends it and keeps outputs idle
    wr(4'h0, 32'h0000_0014);
    pulse_trig(3);
    repeat (6) @(negedge clk);
    check("pulse running", pulse_out, 1);
    @(posedge clk);
    clr <= 1'b1;
    repeat (5) @(negedge clk);
    check("cleared outputs", {pulse_out, pulse_out_n, osc_out}, 3'b010);
    rd(4'h8, q);
    check("status cleared", q[5:2], 4'h8);
    clr <= 1'b0;
    $display("test clear done");
    final_report();
  end
endmodule // retriggerable_multivibrator_bench
`default_nettype wire
